// ### rtl/lcdsc_regs.vh
`ifndef LCDSC_REGS_VH
`define LCDSC_REGS_VH
// Register addresses
`define LCDSC_ADDR_CLK_GATE   16'hFF4A
`define LCDSC_ADDR_MODE       16'hFF90
`define LCDSC_ADDR_CTRL       16'hFF92
// Display memory window
`define LCDSC_MEM_FIRST       16'hFA58
`define LCDSC_MEM_LAST        16'hFA7F
`define LCDSC_MEM_WORDS       40
`define LCDSC_MEM_IDX_W       6
// Field positions
`define LCDSC_MODE_ON_BIT     7
`define LCDSC_MODE_SEL_HI     6
`define LCDSC_MODE_SEL_LO     4
`define LCDSC_CTRL_PWR_BIT    0
`define LCDSC_CTRL_FIXED_BIT  7
`define LCDSC_GATE_SUPPLY_BIT 1
// Reset value and masks
`define LCDSC_RESET_BYTE      8'h00
`define LCDSC_MODE_MASK       8'hF0
`define LCDSC_CTRL_MASK       8'h81
`define LCDSC_NIBBLE_MASK     8'h0F
// Divider: main clock / 2^(17 - sel)
`define LCDSC_DIV_W           17
`define LCDSC_DIV_BASE_EXP    17
`define LCDSC_SEL_MAX         3'h3
// Scan
`define LCDSC_SEGS            40
`define LCDSC_COMS            4
`endif

// ### rtl/lcdsc_seg_cell.v
`timescale 1ns/1ps
// One driver pin: select flag and polarity to a drive level code
// Level codes: 2'h0 ground, 2'h1 one third, 2'h2 two thirds, 2'h3 top
module lcdsc_seg_cell (
  // Clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // Control
  input  wire       is_common,
  input  wire       sel,
  input  wire       polarity,
  input  wire       run,
  // Drive level
  output reg  [1:0] level
);
  reg [1:0] next_level;

  always @* begin
    // Select levels are the rails; non-select sit on the inner taps
    if (is_common)
      next_level = sel ? (polarity ? 2'h0 : 2'h3) : (polarity ? 2'h2 : 2'h1);
    else
      next_level = sel ? (polarity ? 2'h3 : 2'h0) : (polarity ? 2'h1 : 2'h2);
  end

  always @(posedge clk) begin
    if (!reset_n)
      level <= 2'h0;
    else if (run)
      level <= next_level;
  end
endmodule

// ### rtl/lcdsc_driver.v
`timescale 1ns/1ps
`include "lcdsc_regs.vh"
//////////////////////////////////////////////////////////////////////////////
module lcdsc_driver (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // Processor memory port
  input  wire [15:0] cpu_addr,
  input  wire        cpu_wr,
  input  wire        cpu_rd,
  input  wire [7:0]  cpu_wdata,
  output reg  [7:0]  cpu_rdata,
  output reg         cpu_hit,
  // Port function selection
  input  wire [4:0]  port_function_bytes,
  input  wire [15:0] port_function_bits,
  // Panel drive, two-bit level codes, and one LCD function flag per segment pin
  output wire [79:0] segment_level,
  output wire [7:0]  common_level,
  output wire [39:0] segment_is_lcd,
  // Ladder control and LCD scan clock
  output wire        drive_power_sel,
  output wire        lcd_scan_clock
);
  //////////////////////////////////////////////////////////////////////////////
  reg  [7:0]  lcd_mode_reg;
  reg  [7:0]  lcd_ctrl_reg;
  reg  [7:0]  lcd_clk_gate_reg;
  reg  [3:0]  disp_mem [0:`LCDSC_MEM_WORDS-1];
  reg  [`LCDSC_DIV_W-1:0] div_cnt;
  reg  [1:0]  com_slot;
  reg         polarity;
  reg         scan_tick;
  reg  [7:0]  next_rdata;
  reg         next_hit;
  reg  [`LCDSC_DIV_W-1:0] div_limit;
  reg         lcd_clk_level;

  wire        display_on_bit     = lcd_mode_reg[`LCDSC_MODE_ON_BIT];
  wire [2:0]  lcd_clk_sel        = lcd_mode_reg[`LCDSC_MODE_SEL_HI:`LCDSC_MODE_SEL_LO];
  wire        lcd_clk_supply_bit = lcd_clk_gate_reg[`LCDSC_GATE_SUPPLY_BIT];
  wire        mem_hit = (cpu_addr >= `LCDSC_MEM_FIRST) && (cpu_addr <= `LCDSC_MEM_LAST);
  wire [15:0] mem_off = cpu_addr - `LCDSC_MEM_FIRST;
  wire [`LCDSC_MEM_IDX_W-1:0] mem_idx = mem_off[`LCDSC_MEM_IDX_W-1:0];
  integer     i;

  assign drive_power_sel = lcd_ctrl_reg[`LCDSC_CTRL_PWR_BIT];
  assign lcd_scan_clock  = lcd_clk_level;

  //////////////////////////////////////////////////////////////////////////////
  // Register and memory writes
  always @(posedge clk) begin
    if (!reset_n) begin
      lcd_mode_reg     <= `LCDSC_RESET_BYTE;
      lcd_ctrl_reg     <= `LCDSC_RESET_BYTE;
      lcd_clk_gate_reg <= `LCDSC_RESET_BYTE;
    end else if (cpu_wr) begin
      case (cpu_addr)
        `LCDSC_ADDR_MODE:     lcd_mode_reg     <= cpu_wdata & `LCDSC_MODE_MASK;
        // Fixed bits are kept as software writes them; only bit 0 acts
        `LCDSC_ADDR_CTRL:     lcd_ctrl_reg     <= cpu_wdata & `LCDSC_CTRL_MASK;
        `LCDSC_ADDR_CLK_GATE: lcd_clk_gate_reg <= cpu_wdata;
        default: ;
      endcase
    end
  end

  // Memory has no reset: contents are software's to initialise first
  always @(posedge clk) begin
    if (cpu_wr && mem_hit)
      disp_mem[mem_idx] <= cpu_wdata[3:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path, registered one cycle after the strobe
  always @* begin
    next_rdata = `LCDSC_RESET_BYTE;
    next_hit   = 1'b0;
    if (cpu_rd) begin
      if (mem_hit) begin
        next_rdata = {4'h0, disp_mem[mem_idx]} & `LCDSC_NIBBLE_MASK;
        next_hit   = 1'b1;
      end else if (cpu_addr == `LCDSC_ADDR_MODE) begin
        next_rdata = lcd_mode_reg;
        next_hit   = 1'b1;
      end else if (cpu_addr == `LCDSC_ADDR_CTRL) begin
        next_rdata = lcd_ctrl_reg;
        next_hit   = 1'b1;
      end
      // Clock gate register is write-only and reads as zero
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      cpu_rdata <= `LCDSC_RESET_BYTE;
      cpu_hit   <= 1'b0;
    end else begin
      cpu_rdata <= next_rdata;
      cpu_hit   <= next_hit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // LCD clock divider from the main clock only
  always @* begin
    // Prohibited codes fall back to the slowest rate rather than misbehave
    // The top bit of the active count range is the LCD clock, half high half low
    if (lcd_clk_sel > `LCDSC_SEL_MAX) begin
      div_limit     = {`LCDSC_DIV_W{1'b1}};
      lcd_clk_level = div_cnt[`LCDSC_DIV_W-1];
    end else begin
      div_limit     = {`LCDSC_DIV_W{1'b1}} >> lcd_clk_sel;
      lcd_clk_level = div_cnt[`LCDSC_DIV_W-1-lcd_clk_sel];
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      div_cnt   <= {`LCDSC_DIV_W{1'b0}};
      scan_tick <= 1'b0;
    end else if (!lcd_clk_supply_bit) begin
      div_cnt   <= {`LCDSC_DIV_W{1'b0}};
      scan_tick <= 1'b0;
    end else begin
      scan_tick <= (div_cnt >= div_limit);
      if (div_cnt >= div_limit)
        div_cnt <= {`LCDSC_DIV_W{1'b0}};
      else
        div_cnt <= div_cnt + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Common scan: one slot per LCD clock, polarity flips each frame
  always @(posedge clk) begin
    if (!reset_n) begin
      com_slot <= 2'h0;
      polarity <= 1'b0;
    end else if (scan_tick && lcd_clk_supply_bit) begin
      com_slot <= com_slot + 1'b1;
      if (com_slot == 2'h3)
        polarity <= ~polarity;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Drivers; outputs update at each slot start, read straight from memory
  genvar g;
  generate
    for (g = 0; g < `LCDSC_SEGS; g = g + 1) begin : seg
      // Segment g reads the byte counted down from the top address
      wire [3:0] byte_bits = disp_mem[`LCDSC_MEM_WORDS-1-g];
      wire       seg_sel   = display_on_bit & byte_bits[com_slot];
      lcdsc_seg_cell u_cell (
        .clk       (clk),
        .reset_n   (reset_n),
        .is_common (1'b0),
        .sel       (seg_sel),
        .polarity  (polarity),
        .run       (scan_tick),
        .level     (segment_level[2*g+1:2*g])
      );
    end
    for (g = 0; g < `LCDSC_COMS; g = g + 1) begin : com
      lcdsc_seg_cell u_cell (
        .clk       (clk),
        .reset_n   (reset_n),
        .is_common (1'b1),
        .sel       (com_slot == g),
        .polarity  (polarity),
        .run       (scan_tick),
        .level     (common_level[2*g+1:2*g])
      );
    end
  endgenerate

  // Pins 0..23 switch by byte group, 24..39 per pin
  assign segment_is_lcd = {port_function_bits,
                           {8{port_function_bytes[2]}},
                           {8{port_function_bytes[1]}},
                           {8{port_function_bytes[0]}}};
endmodule

// ### testbench/lcdsc_glass_model.sv
`timescale 1ns/1ps
module lcdsc_glass_model (
  // Electrodes
  input  logic [79:0] segment_level,
  input  logic [7:0]  common_level,
  // Rows and segments at full swing
  output logic [3:0]  row_lit,
  output logic [39:0] col_lit
);
  // A passive panel only sees the voltage between its two electrodes
  always_comb begin
    for (int c = 0; c < 4; c++) row_lit[c] = ~^common_level[2*c+:2];
    for (int g = 0; g < 40; g++) col_lit[g] = segment_level[2*g+:2] == ~{2{common_level[0]}};
  end
endmodule

// ### testbench/lcdsc_driver_props.sv
`timescale 1ns/1ps
module lcdsc_driver_props (
  // Clock and reset
  input logic        clk,
  input logic        reset_n,
  // Register access
  input logic [15:0] cpu_addr,
  input logic        cpu_wr,
  input logic        cpu_rd,
  input logic [7:0]  cpu_wdata,
  input logic [7:0]  cpu_rdata,
  input logic        cpu_hit,
  // Panel
  input logic [79:0] segment_level,
  input logic [7:0]  common_level,
  input logic        drive_power_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A common at top or ground is the selected one
  wire [3:0] sel = ~{^common_level[7:6], ^common_level[5:4],
                     ^common_level[3:2], ^common_level[1:0]};
  wire       mem = cpu_addr >= 16'hFA58 && cpu_addr <= 16'hFA7F;
  wire       on  = |common_level;
  ////////////////////////////////////////
  property p_hit; cpu_rd && (mem || cpu_addr == 16'hFF90) |=> cpu_hit; endproperty
  a_hit: assert property (p_hit) else $error("read not answered");
  property p_gate; cpu_rd && cpu_addr == 16'hFF4A |=> !cpu_hit && cpu_rdata == 8'h00; endproperty
  a_gate: assert property (p_gate) else $error("gate register readable");
  property p_high; cpu_rd && mem |=> cpu_rdata[7:4] == 4'h0; endproperty
  a_high: assert property (p_high) else $error("upper nibble set");
  property p_pwr; cpu_wr && cpu_addr == 16'hFF92
    |=> drive_power_sel == $past(cpu_wdata[0]); endproperty
  a_pwr: assert property (p_pwr) else $error("power bit wrong");
  property p_one; on |-> $onehot(sel); endproperty
  a_one: assert property (p_one) else $error("not one common selected");
  property p_next; $changed(common_level) && $past(on)
    |-> sel == {$past(sel[2:0]), $past(sel[3])}; endproperty
  a_next: assert property (p_next) else $error("common order wrong");
  property p_flip; $changed(common_level) && $past(on)
    |-> (common_level[0] != $past(common_level[0])) == $past(sel[3]); endproperty
  a_flip: assert property (p_flip) else $error("polarity flip wrong");
  property p_bias; on |-> (segment_level & {40{2'h1}}) == {40{1'b0, ~common_level[0]}}
    && (common_level & 8'h55) == {4{1'b0, common_level[0]}}; endproperty
  a_bias: assert property (p_bias) else $error("polarity mixed");
  c_wrap: cover property (sel[3] ##1 sel[0]);
  c_mem: cover property (cpu_rd && mem);
  c_pwr: cover property (cpu_wr && cpu_addr == 16'hFF92);
endmodule

// ### testbench/lcd_segment_common_driver_bench.sv
`timescale 1ns/1ps
module lcd_segment_common_driver_bench;
  logic        clk, reset_n, cpu_wr, cpu_rd, cpu_hit, drive_power_sel, lcd_scan_clock;
  logic [15:0] cpu_addr, port_function_bits;
  logic [7:0]  cpu_wdata, cpu_rdata, common_level;
  logic [4:0]  port_function_bytes;
  logic [79:0] segment_level;
  logic [39:0] segment_is_lcd, col_lit;
  logic [3:0]  row_lit;
  int          n_mismatch, tests_run, n;
  lcdsc_driver DUT (.clk, .reset_n, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata,
    .cpu_hit, .port_function_bytes, .port_function_bits, .segment_level, .common_level,
    .segment_is_lcd, .drive_power_sel, .lcd_scan_clock);
  lcdsc_glass_model u_glass (.segment_level, .common_level, .row_lit, .col_lit);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  function automatic logic [7:0] pat(int g);
    return 8'((g * 5 + 1) % 16);
  endfunction
  task automatic chk(string nm, logic [79:0] got, logic [79:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic bus(int a, logic w, logic r, logic [7:0] d);
    cpu_addr = 16'(a);
    cpu_wdata = d;
    cpu_wr = w;
    cpu_rd = r;
    @(negedge clk);
  endtask
  task automatic rd(int a, logic [8:0] e);
    bus(a, 0, 1, 8'h00);
    chk("read", {cpu_hit, cpu_rdata}, e);
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Waits for the next slot; a missing slot ends the run
  task automatic slot(int k, logic p, logic on);
    logic [7:0]  prev;
    logic [39:0] e;
    int          hi;
    hi = 0;
    prev = common_level;
    for (n = 0; common_level === prev; n++) begin
      if (n > 20000) begin
        n_mismatch++;
        summarize();
      end
      @(negedge clk);
      hi += int'(lcd_scan_clock);
    end
    for (int g = 0; g < 40; g++) e[g] = 1'(on & (pat(g) >> k));
    if (k > 1) chk("len", n, 16384);
    if (k > 1) chk("lcdclk", hi, 8192);
    chk("rows", row_lit, 4'h1 << k);
    chk("cols", col_lit, e);
    chk("pol", common_level[0], !p);
    $display("end slot %0d", k);
  endtask
  ////////////////////////////////////////
  initial begin
    {reset_n, cpu_wr, cpu_rd} = 3'h0;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    port_function_bytes = 5'h07;
    port_function_bits = 16'hFFFF;
    repeat (3) @(negedge clk);
    reset_n = 1;
    rd(16'hFF90, 9'h100);
    rd(16'hFF92, 9'h100);
    rd(16'hFF4A, 9'h000);
    rd(16'hFA80, 9'h000);
    bus(16'hFF90, 1, 0, 8'h3F);
    rd(16'hFF90, 9'h130);
    $display("end regs");
    for (int g = 0; g < 40; g++) bus(16'hFA7F - g, 1, 0, pat(g));
    for (int g = 0; g < 40; g++) rd(16'hFA7F - g, {1'b1, pat(g)});
    port_function_bytes = 5'h05;
    port_function_bits = 16'h00F0;
    bus(0, 0, 0, 8'h00);
    chk("pins", segment_is_lcd, 40'h00F0FF00FF);
    port_function_bytes = 5'h07;
    port_function_bits = 16'hFFFF;
    $display("end memory");
    bus(16'hFF92, 1, 0, 8'h81);
    bus(16'hFF90, 1, 0, 8'hB0);
    chk("power", drive_power_sel, 1'b1);
    bus(0, 0, 0, 8'h00);
    repeat (16400) @(negedge clk);
    chk("halted", common_level, 8'h00);
    bus(16'hFF4A, 1, 0, 8'h02);
    bus(0, 0, 0, 8'h00);
    for (int k = 0; k < 4; k++) slot(k, 0, 1);
    bus(16'hFF90, 1, 0, 8'h30);
    bus(0, 0, 0, 8'h00);
    slot(0, 1, 0);
    chk("off", segment_level, {40{2'h1}});
    summarize();
  end
endmodule
bind lcdsc_driver lcdsc_driver_props u_props (.clk, .reset_n, .cpu_addr, .cpu_wr, .cpu_rd,
  .cpu_wdata, .cpu_rdata, .cpu_hit, .segment_level, .common_level, .drive_power_sel);
